//--- bench/microcode_patch_loader_test.sv
// Self-checking bench for the patch loader controller
`default_nettype none
module microcode_patch_loader_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Connections
  logic        ref_clk, resetn, sw_wr, sw_rd, hard_rst, mem_rd, mem_rvalid;
  logic        dev_req_valid, dev_ack, cache_init_ok;
  logic [7:0]  sw_addr;
  logic [31:0] sw_wdata, sw_rdata, mem_addr, mem_rdata, rd;
  logic [63:0] dev_rdata;
  logic [1:0]  lat;
  patch_pkg::dev_req_t dev_req;
  // Bench state
  int          fails, comparisons, seed, n;
  logic [31:0] cur_rev, rev, base;
  patch_loader_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .dev_req_valid(dev_req_valid), .dev_req(dev_req), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata), .hard_rst(hard_rst), .cache_init_ok(cache_init_ok));
  patch_dev_model i_dev (.ref_clk(ref_clk), .lat(lat), .dev_req_valid(dev_req_valid),
    .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .hard_rst(hard_rst));
  // 250 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 rd = sw_rdata;
  endtask : rdr
  // Outcome code; the two prechecks can refuse before any image read
  function automatic logic [3:0] exp_code(input logic [4:0] ctl, input logic [31:0] ldr,
                                          input logic cpu_ok, input logic sum_ok);
    if (ctl[3] && !ctl[4]) return 4'h7;
    if (ctl[2] && base[15:0] > 16'hf800) return 4'h6;
    if (ctl[1] && !sum_ok) return 4'h1;
    if (ldr != 32'h1) return 4'h2;
    if (!cpu_ok) return 4'h3;
    if (rev <= cur_rev) return 4'h4;
    if (i_dev.corrupt) return 4'h5;
    return 4'h0;
  endfunction : exp_code
  // Build an image at base, configure, start, wait for completion and check
  task automatic run(input logic [4:0] ctl, input logic [31:0] ldr,
                     input logic cpu_ok, input logic sum_ok);
    logic [31:0] w [512];
    logic [31:0] s;
    logic [3:0]  code;
    s = 32'h0;
    code = exp_code(ctl, ldr, cpu_ok, sum_ok);
    for (int i = 0; i < 512; i++)
    begin
      w[i] = $random(seed);
      case (i)
        1: w[i] = rev;
        3: w[i] = 32'h0000_0a51;
        4: w[i] = 32'h0;
        5: w[i] = ldr;
        6: w[i] = 32'h0000_0004;
        default: ;
      endcase
      s = s + w[i];
    end
    w[4] = 32'h0 - s + {31'h0, !sum_ok};
    for (int i = 0; i < 2048; i++)
      i_dev.img[base + i] = w[i / 4][8 * (i % 4) +: 8];
    lat <= 2'($random(seed));
    wr(patch_pkg::OFS_BASE, base);
    wr(patch_pkg::OFS_CPU, cpu_ok ? 32'h0000_0a51 : 32'h0000_0a52);
    wr(patch_pkg::OFS_PLAT, 32'h0000_0006);
    wr(patch_pkg::OFS_CTRL, {27'h0, ctl} | 32'h1);
    n = 0;
    do
    begin
      rdr(patch_pkg::OFS_STAT);
      n++;
    end while ((rd[0] !== 1'b0 || rd[1] !== 1'b1) && n < 4000);
    chk("load finished", 32'h1, {31'h0, n < 4000});
    repeat (3) @(posedge ref_clk);
    #1 chk("status code", {28'h0, code}, {28'h0, rd[11:8]});
    chk("ok bit", {31'h0, code == 4'h0}, {31'h0, rd[2]});
    chk("cache init ok", {31'h0, code == 4'h0}, {31'h0, cache_init_ok});
    if (code < 4'h6)
    begin
      rdr(patch_pkg::OFS_HDR);
      chk("header revision", rev, rd);
    end
    if (code == 4'h0 || code == 4'h4)
    begin
      rdr(patch_pkg::OFS_OLD);
      chk("old revision", cur_rev, rd);
    end
    if (code == 4'h0)
    begin
      rdr(patch_pkg::OFS_NEW);
      chk("new revision", rev, rd);
      chk("trigger address", base + patch_pkg::PAYLOAD_OFS, i_dev.trig_eax);
      chk("trigger high half", 32'h0, i_dev.trig_edx);
      cur_rev = rev;
    end
  endtask : run
  // Hang guard, well beyond the expected length of the run
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    seed = int'(32'ha398a98a);
    {sw_addr, sw_wdata, sw_wr, sw_rd, hard_rst, lat, resetn} = '0;
    fails = 0;
    comparisons = 0;
    cur_rev = 32'h0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rdr(patch_pkg::OFS_STAT);
    chk("status after reset", 32'h0, rd);
    rdr(8'h40);
    chk("unmapped read", 32'h0, rd);
    wr(patch_pkg::OFS_STAT, 32'hffff_ffff);
    rdr(patch_pkg::OFS_STAT);
    chk("read-only status", 32'h0, rd);
    rev = ($random(seed) & 32'h00ff_fff0) + 32'h10;
    base = ($random(seed) & 32'h0fff_7fff) | 32'h1;
    run(5'h02, 32'h1, 1'b1, 1'b1);
    run(5'h02, 32'h1, 1'b1, 1'b1);
    hard_rst <= 1'b1;
    @(posedge ref_clk);
    hard_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("cache init after hard reset", 32'h0, {31'h0, cache_init_ok});
    rdr(patch_pkg::OFS_STAT);
    chk("reload flag", 32'h1, {31'h0, rd[3]});
    cur_rev = 32'h0;
    run(5'h00, 32'h1, 1'b1, 1'b1);
    rev = rev + 32'h1;
    run(5'h02, 32'h1, 1'b1, 1'b0);
    run(5'h00, 32'h2, 1'b1, 1'b1);
    run(5'h00, 32'h1, 1'b0, 1'b1);
    base[15:0] = 16'hf801;
    run(5'h04, 32'h1, 1'b1, 1'b1);
    base[15:0] = 16'hf800;
    run(5'h04, 32'h1, 1'b1, 1'b1);
    rev = rev + 32'h1;
    base = base + 32'h0001_0002;
    run(5'h08, 32'h1, 1'b1, 1'b1);
    run(5'h18, 32'h1, 1'b1, 1'b1);
    rev = rev + 32'h1;
    i_dev.corrupt = 1'b1;
    run(5'h00, 32'h1, 1'b1, 1'b1);
    i_dev.corrupt = 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rdr(patch_pkg::OFS_STAT);
    chk("status after soft init", 32'h0, rd);
    rev = rev + 32'h1;
    run(5'h00, 32'h1, 1'b1, 1'b1);
    stop_test();
  end
endmodule : microcode_patch_loader_test
`default_nettype wire

//--- bench/patch_dev_model.sv
// Behavioural processor model: patch registers, identify and image memory
`default_nettype none
module patch_dev_model (
  // Clock and answer delay
  input  wire logic                ref_clk,
  input  wire logic [1:0]          lat,
  // Model register and identify port
  input  wire logic                dev_req_valid,
  input  wire patch_pkg::dev_req_t dev_req,
  output logic                     dev_ack,
  output logic [63:0]              dev_rdata,
  // Image memory
  input  wire logic                mem_rd,
  input  wire logic [31:0]         mem_addr,
  output logic                     mem_rvalid,
  output logic [31:0]              mem_rdata,
  // Platform
  input  wire logic                hard_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  img [logic [31:0]];
  logic [31:0] rev_r = 32'h0;
  logic [31:0] trig_eax = 32'h0;
  logic [31:0] trig_edx = 32'h0;
  logic [31:0] maddr = 32'h0;
  logic [63:0] sig_r = 64'h0;
  logic [1:0]  dcnt = 2'h0;
  logic [1:0]  mcnt = 2'h0;
  logic        mbusy = 1'b0;
  logic        corrupt = 1'b0; // Bench sets it so the trigger loads a wrong revision
  initial dev_ack = 1'b0;
  initial dev_rdata = 64'h5a5a_a5a5_0ff0_f00f;
  initial mem_rvalid = 1'b0;
  initial mem_rdata = 32'h3c3c_c3c3;
  function automatic logic [31:0] rd32(input logic [31:0] a);
    return {img[a + 3], img[a + 2], img[a + 1], img[a]};
  endfunction : rd32
  // Operations; the patch survives a controller reset, only hard reset drops it
  always @(posedge ref_clk)
  begin
    dev_ack <= 1'b0;
    dev_rdata <= ~dev_rdata;  // Released data never shows the last value
    if (hard_rst)
      rev_r <= 32'h0;
    if (dev_req_valid && !dev_ack)
    begin
      dcnt <= dcnt + 2'h1;
      if (dcnt == lat)
      begin
        dcnt <= 2'h0;
        dev_ack <= 1'b1;
        if (dev_req.op == patch_pkg::OP_WR && dev_req.ecx == patch_pkg::TRIG_ADDR)
        begin
          rev_r <= rd32(dev_req.eax - patch_pkg::PAYLOAD_OFS + 32'h4)
                   - {31'h0, corrupt};
          trig_eax <= dev_req.eax;
          trig_edx <= dev_req.edx;
        end
        if (dev_req.op == patch_pkg::OP_WR && dev_req.ecx == patch_pkg::SIG_ADDR)
          sig_r <= {dev_req.edx, dev_req.eax};
        if (dev_req.op == patch_pkg::OP_ID && rev_r != 32'h0)
          sig_r <= {rev_r, 32'h0};
        if (dev_req.op == patch_pkg::OP_RD)
          dev_rdata <= (dev_req.ecx == patch_pkg::SIG_ADDR) ? sig_r : 64'h0;
      end
    end
  end
  // Image reads answered after a variable delay
  always @(posedge ref_clk)
  begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_rd)
    begin
      mbusy <= 1'b1;
      mcnt <= 2'h0;
      maddr <= mem_addr;
    end
    else if (mbusy)
    begin
      mcnt <= mcnt + 2'h1;
      if (mcnt == lat)
      begin
        mbusy <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= rd32(maddr);
      end
    end
  end
endmodule : patch_dev_model
`default_nettype wire

//--- rtl/dev_op_issuer.sv
// Holds one device operation until the device acknowledges it
`default_nettype none
module dev_op_issuer (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // From the sequencer
  input  wire logic               issue,
  input  wire patch_pkg::dev_req_t req_in,
  output logic                    op_done,
  output logic [63:0]             rdata,
  // Device side
  output logic                    req_valid,
  output var patch_pkg::dev_req_t req_out,
  input  wire logic               dev_ack,
  input  wire logic [63:0]        dev_rdata
);
  // Request registers stay put so the device sees stable operands
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      req_valid <= 1'b0;
      req_out   <= '0;
    end
    else if (issue && !req_valid)
    begin
      req_valid <= 1'b1;
      req_out   <= req_in;
    end
    else if (dev_ack)
      req_valid <= 1'b0;

  // Completion pulse and returned data
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      op_done <= 1'b0;
      rdata   <= '0;
    end
    else
    begin
      op_done <= dev_ack && req_valid;
      if (dev_ack && req_valid)
        rdata <= dev_rdata;
    end

  req_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    req_valid && !dev_ack |=> req_valid && $stable(req_out))
    else $error("request changed before ack");
endmodule : dev_op_issuer
`default_nettype wire

//--- rtl/dword_sum.sv
// Running sum of image dwords for the integrity check
`default_nettype none
module dword_sum #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // Accumulate control
  input  wire logic         clr,
  input  wire logic         add,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] sum
);
  // Wraps modulo 2^W, which is what a zero-sum check wants
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      sum <= '0;
    else if (clr)
      sum <= '0;
    else if (add)
      sum <= sum + din;

  sum_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clr |=> sum == '0) else $error("sum not cleared");
endmodule : dword_sum
`default_nettype wire

//--- rtl/patch_loader_ctrl.sv
// Firmware-side controller that loads and authenticates a patch image
//
// How it works
// - Trigger write: address low, zero high
// - Trigger address is image start plus 48
// - Load before second-level cache initialisation
// - Real mode: image stays inside segment
// - Paging: image pages mapped before trigger
// - Hard reset drops patch; reload needed
// - Each processor gets its matching patch
// - Clear signature before identify; zero means none
// - Signature query: clear, identify, read
// - Load only newer; verify new signature
// - No patch counts as revision zero
// - Optional dword sum must be zero
// - Sequence valid for loader revision one
// - Image 2048 bytes, 48-byte header
`default_nettype none
module patch_loader_ctrl (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // Software register port
  input  wire logic [7:0]         sw_addr,
  input  wire logic [31:0]        sw_wdata,
  input  wire logic               sw_wr,
  input  wire logic               sw_rd,
  output logic [31:0]             sw_rdata,
  // Image memory read port
  output logic                    mem_rd,
  output logic [31:0]             mem_addr,
  input  wire logic               mem_rvalid,
  input  wire logic [31:0]        mem_rdata,
  // Device model register and identify port
  output logic                    dev_req_valid,
  output var patch_pkg::dev_req_t dev_req,
  input  wire logic               dev_ack,
  input  wire logic [63:0]        dev_rdata,
  // Platform
  input  wire logic               hard_rst,
  output logic                    cache_init_ok
);
  patch_pkg::state_t   state_r;
  patch_pkg::fail_t    fail_r;
  patch_pkg::fail_t    pre_fail;
  patch_pkg::fail_t    chk_fail;
  patch_pkg::fail_t    rev_fail;
  patch_pkg::dev_req_t req_nxt;
  logic [4:0]          ctrl_r;
  logic [31:0]         base_r;
  logic [31:0]         cpu_r;
  logic [31:0]         plat_r;
  logic [31:0]         hdr_rev_r;
  logic [31:0]         proc_r;
  logic [31:0]         ldr_r;
  logic [31:0]         flags_r;
  logic [31:0]         old_rev_r;
  logic [31:0]         new_rev_r;
  logic [31:0]         sum;
  logic [31:0]         rev;
  logic [31:0]         stat;
  logic [63:0]         op_rdata;
  logic [9:0]          idx_r;
  logic                pass_r;
  logic                sent_r;
  logic                done_r;
  logic                reload_r;
  logic                start;
  logic                scan_add;
  logic                dev_state;
  logic                issue;
  logic                op_done;

  // A start is only taken while idle; later starts are dropped
  assign start    = sw_wr && sw_addr == patch_pkg::OFS_CTRL
                    && sw_wdata[patch_pkg::CB_START]
                    && state_r == patch_pkg::ST_IDLE;
  assign scan_add = state_r == patch_pkg::ST_SCAN && mem_rvalid;
  assign rev      = op_rdata[63:32];
  assign dev_state = state_r == patch_pkg::ST_CLR || state_r == patch_pkg::ST_IDN
                     || state_r == patch_pkg::ST_RDS || state_r == patch_pkg::ST_TRIG;
  assign issue    = dev_state && !sent_r;

  // Checks made before any memory is touched
  always_comb
  begin
    pre_fail = patch_pkg::FAIL_NONE;
    if (sw_wdata[patch_pkg::CB_REAL]
        && (sw_wdata[patch_pkg::CB_REAL] ? (base_r & patch_pkg::SEG_MASK) : '0)
           + patch_pkg::IMAGE_BYTES > patch_pkg::SEG_SPAN)
      pre_fail = patch_pkg::FAIL_SEG;
    else if (sw_wdata[patch_pkg::CB_PAGING] && !sw_wdata[patch_pkg::CB_MAPPED])
      pre_fail = patch_pkg::FAIL_PAGE;
  end

  // Header and integrity checks after the scan
  always_comb
  begin
    chk_fail = patch_pkg::FAIL_NONE;
    if (ctrl_r[patch_pkg::CB_SUM] && sum != '0)
      chk_fail = patch_pkg::FAIL_SUM;
    else if (ldr_r != patch_pkg::LDR_REV_OK)
      chk_fail = patch_pkg::FAIL_LDR;
    else if (proc_r != cpu_r || (flags_r & plat_r & patch_pkg::PLAT_MASK) == '0)
      chk_fail = patch_pkg::FAIL_CPU;
  end

  // Zero read back is simply revision zero, so no special case
  always_comb
  begin
    rev_fail = patch_pkg::FAIL_NONE;
    if (pass_r && rev != hdr_rev_r)
      rev_fail = patch_pkg::FAIL_VERIFY;
    else if (!pass_r && !(hdr_rev_r > rev))
      rev_fail = patch_pkg::FAIL_OLD;
  end

  // Operation for the current step
  always_comb
  begin
    req_nxt = '0;
    case (state_r)
      patch_pkg::ST_CLR:
      begin
        req_nxt.op  = patch_pkg::OP_WR;
        req_nxt.ecx = patch_pkg::SIG_ADDR;
      end
      patch_pkg::ST_IDN:
      begin
        req_nxt.op  = patch_pkg::OP_ID;
        req_nxt.eax = patch_pkg::ID_LEAF;
      end
      patch_pkg::ST_RDS:
      begin
        req_nxt.op  = patch_pkg::OP_RD;
        req_nxt.ecx = patch_pkg::SIG_ADDR;
      end
      patch_pkg::ST_TRIG:
      begin
        req_nxt.op  = patch_pkg::OP_WR;
        req_nxt.ecx = patch_pkg::TRIG_ADDR;
        req_nxt.eax = base_r + patch_pkg::PAYLOAD_OFS;
        req_nxt.edx = '0;
      end
      default:
        req_nxt = '0;
    endcase
  end

  // Sequencer
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      state_r <= patch_pkg::ST_IDLE;
    else
    begin
      case (state_r)
        patch_pkg::ST_IDLE:
          if (start)
            state_r <= pre_fail != patch_pkg::FAIL_NONE ? patch_pkg::ST_END
                                                       : patch_pkg::ST_SCAN;
        patch_pkg::ST_SCAN:
          if (scan_add && idx_r == patch_pkg::IDX_LAST)
            state_r <= patch_pkg::ST_CHECK;
        patch_pkg::ST_CHECK:
          state_r <= chk_fail != patch_pkg::FAIL_NONE ? patch_pkg::ST_END
                                                     : patch_pkg::ST_CLR;
        patch_pkg::ST_CLR:
          if (op_done)
            state_r <= patch_pkg::ST_IDN;
        patch_pkg::ST_IDN:
          if (op_done)
            state_r <= patch_pkg::ST_RDS;
        patch_pkg::ST_RDS:
          if (op_done)
            state_r <= (pass_r || rev_fail != patch_pkg::FAIL_NONE)
                       ? patch_pkg::ST_END : patch_pkg::ST_TRIG;
        patch_pkg::ST_TRIG:
          if (op_done)
            state_r <= patch_pkg::ST_CLR;
        patch_pkg::ST_END:
          state_r <= patch_pkg::ST_IDLE;
        default:
          state_r <= patch_pkg::ST_IDLE;
      endcase
    end

  // Software configuration, frozen while a load runs
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      ctrl_r <= '0;
      base_r <= '0;
      cpu_r  <= '0;
      plat_r <= '0;
    end
    else if (sw_wr && state_r == patch_pkg::ST_IDLE)
    begin
      if (sw_addr == patch_pkg::OFS_CTRL)
        ctrl_r <= sw_wdata[4:0];
      if (sw_addr == patch_pkg::OFS_BASE)
        base_r <= sw_wdata;
      if (sw_addr == patch_pkg::OFS_CPU)
        cpu_r <= sw_wdata;
      if (sw_addr == patch_pkg::OFS_PLAT)
        plat_r <= sw_wdata;
    end

  // Image scan: one outstanding dword read at a time, whole 2 KiB image
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      idx_r    <= '0;
      mem_rd   <= 1'b0;
      mem_addr <= '0;
    end
    else
    begin
      mem_rd <= 1'b0;
      if (start && pre_fail == patch_pkg::FAIL_NONE)
      begin
        idx_r    <= '0;
        mem_rd   <= 1'b1;
        mem_addr <= base_r;
      end
      else if (scan_add && idx_r != patch_pkg::IDX_LAST)
      begin
        idx_r    <= idx_r + 10'h001;
        mem_rd   <= 1'b1;
        mem_addr <= base_r + (32'(idx_r + 10'h001) << patch_pkg::DW_SHIFT);
      end
    end

  // Header fields picked out of the scan
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      hdr_rev_r <= '0;
      proc_r    <= '0;
      ldr_r     <= '0;
      flags_r   <= '0;
    end
    else if (scan_add)
    begin
      if (idx_r == patch_pkg::IDX_REV)
        hdr_rev_r <= mem_rdata;
      if (idx_r == patch_pkg::IDX_PROC)
        proc_r <= mem_rdata;
      if (idx_r == patch_pkg::IDX_LDR)
        ldr_r <= mem_rdata;
      if (idx_r == patch_pkg::IDX_FLAGS)
        flags_r <= mem_rdata;
    end

  // One device operation per step; cleared when it completes
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      sent_r <= 1'b0;
    else if (op_done)
      sent_r <= 1'b0;
    else if (issue)
      sent_r <= 1'b1;

  // Signature results and pass tracking
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      pass_r    <= 1'b0;
      old_rev_r <= '0;
      new_rev_r <= '0;
    end
    else if (start)
    begin
      pass_r    <= 1'b0;
      old_rev_r <= '0;
      new_rev_r <= '0;
    end
    else if (state_r == patch_pkg::ST_TRIG && op_done)
      pass_r <= 1'b1;
    else if (state_r == patch_pkg::ST_RDS && op_done)
    begin
      if (pass_r)
        new_rev_r <= rev;
      else
        old_rev_r <= rev;
    end

  // Outcome code
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      fail_r <= patch_pkg::FAIL_NONE;
    else if (start)
      fail_r <= pre_fail;
    else if (state_r == patch_pkg::ST_CHECK)
      fail_r <= chk_fail;
    else if (state_r == patch_pkg::ST_RDS && op_done)
      fail_r <= rev_fail;

  // Hard reset wipes the patch; a reset seen mid-load still forces a reload
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      reload_r      <= 1'b0;
      done_r        <= 1'b0;
      cache_init_ok <= 1'b0;
    end
    else
    begin
      if (hard_rst)
        reload_r <= 1'b1;
      else if (start)
        reload_r <= 1'b0;
      if (start)
        done_r <= 1'b0;
      else if (state_r == patch_pkg::ST_END)
        done_r <= 1'b1;
      if (hard_rst || start)
        cache_init_ok <= 1'b0;
      else if (state_r == patch_pkg::ST_END && fail_r == patch_pkg::FAIL_NONE
               && !reload_r)
        cache_init_ok <= 1'b1;
    end

  // Status word and read port; data only in the cycle after the strobe
  always_comb
  begin
    stat = '0;
    stat[patch_pkg::SB_BUSY]   = state_r != patch_pkg::ST_IDLE;
    stat[patch_pkg::SB_DONE]   = done_r;
    stat[patch_pkg::SB_OK]     = cache_init_ok;
    stat[patch_pkg::SB_RELOAD] = reload_r;
    stat[patch_pkg::SB_CODE +: 4] = fail_r;
  end

  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      sw_rdata <= '0;
    else if (!sw_rd)
      sw_rdata <= '0;
    else
    begin
      case (sw_addr)
        patch_pkg::OFS_CTRL: sw_rdata <= {27'h0, ctrl_r};
        patch_pkg::OFS_BASE: sw_rdata <= base_r;
        patch_pkg::OFS_CPU:  sw_rdata <= cpu_r;
        patch_pkg::OFS_PLAT: sw_rdata <= plat_r;
        patch_pkg::OFS_STAT: sw_rdata <= stat;
        patch_pkg::OFS_OLD:  sw_rdata <= old_rev_r;
        patch_pkg::OFS_NEW:  sw_rdata <= new_rev_r;
        patch_pkg::OFS_HDR:  sw_rdata <= hdr_rev_r;
        default:             sw_rdata <= '0;
      endcase
    end

  dword_sum #(
    .W (32)
  ) u_sum (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clr     (start),
    .add     (scan_add),
    .din     (mem_rdata),
    .sum     (sum)
  );

  dev_op_issuer u_issue (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .issue     (issue),
    .req_in    (req_nxt),
    .op_done   (op_done),
    .rdata     (op_rdata),
    .req_valid (dev_req_valid),
    .req_out   (dev_req),
    .dev_ack   (dev_ack),
    .dev_rdata (dev_rdata)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  trig_operands_a: assert property (dev_req_valid && dev_req.ecx == patch_pkg::TRIG_ADDR
    |-> dev_req.op == patch_pkg::OP_WR && dev_req.edx == '0)
    else $error("trigger operands wrong");
  trig_offset_a: assert property (dev_req_valid && dev_req.ecx == patch_pkg::TRIG_ADDR
    |-> dev_req.eax == base_r + patch_pkg::PAYLOAD_OFS)
    else $error("trigger address not past header");
  seg_limit_a: assert property (issue && state_r == patch_pkg::ST_TRIG
    && ctrl_r[patch_pkg::CB_REAL]
    |-> (base_r & patch_pkg::SEG_MASK) + patch_pkg::IMAGE_BYTES <= patch_pkg::SEG_SPAN)
    else $error("real mode image crosses segment");
  pages_mapped_a: assert property (issue && state_r == patch_pkg::ST_TRIG
    && ctrl_r[patch_pkg::CB_PAGING] |-> ctrl_r[patch_pkg::CB_MAPPED])
    else $error("trigger with pages unmapped");
  id_after_clear_a: assert property (dev_req_valid && dev_req.op == patch_pkg::OP_ID
    |-> dev_req.eax == patch_pkg::ID_LEAF && $past(state_r, 2) != patch_pkg::ST_RDS)
    else $error("identify issued wrongly");
  newer_only_a: assert property (issue && state_r == patch_pkg::ST_TRIG
    |-> hdr_rev_r > old_rev_r && ldr_r == patch_pkg::LDR_REV_OK)
    else $error("trigger for patch not newer");
  match_cpu_a: assert property (issue && state_r == patch_pkg::ST_TRIG
    |-> proc_r == cpu_r && (!ctrl_r[patch_pkg::CB_SUM] || sum == '0))
    else $error("trigger for wrong processor");
  hard_reset_a: assert property (hard_rst |=> reload_r && !cache_init_ok [*2])
    else $error("hard reset did not drop patch");
  cache_gate_a: assert property ($rose(cache_init_ok)
    |-> $past(state_r) == patch_pkg::ST_END && new_rev_r == hdr_rev_r)
    else $error("cache allowed without verified load");
  verify_end_a: assert property (state_r == patch_pkg::ST_RDS && op_done && pass_r
    |=> state_r == patch_pkg::ST_END ##1 done_r)
    else $error("second signature read did not finish");

  load_ok_c: cover property ($rose(cache_init_ok));
  not_newer_c: cover property (state_r == patch_pkg::ST_END
    && fail_r == patch_pkg::FAIL_OLD);
  reset_mid_c: cover property (hard_rst && state_r == patch_pkg::ST_SCAN);
  sum_bad_c: cover property (state_r == patch_pkg::ST_END
    && fail_r == patch_pkg::FAIL_SUM);
  verify_bad_c: cover property (state_r == patch_pkg::ST_END
    && fail_r == patch_pkg::FAIL_VERIFY);
endmodule : patch_loader_ctrl
`default_nettype wire

//--- rtl/patch_pkg.sv
// Constants and types shared by the patch loader controller
`default_nettype none
package patch_pkg;
  // Device model registers
  localparam logic [31:0] TRIG_ADDR   = 32'h0000_0079;
  localparam logic [31:0] SIG_ADDR    = 32'h0000_008b;
  localparam logic [31:0] ID_LEAF     = 32'h0000_0001;
  // Image layout
  localparam logic [31:0] PAYLOAD_OFS = 32'h0000_0030;
  localparam logic [31:0] IMAGE_BYTES = 32'h0000_0800;
  localparam logic [31:0] LDR_REV_OK  = 32'h0000_0001;
  localparam logic [31:0] PLAT_MASK   = 32'h0000_00ff;
  localparam logic [31:0] SEG_SPAN    = 32'h0001_0000;
  localparam logic [31:0] SEG_MASK    = 32'h0000_ffff;
  localparam int          DW_SHIFT    = 2;
  // Dword indices inside the image
  localparam logic [9:0]  IDX_REV     = 10'h001;
  localparam logic [9:0]  IDX_PROC    = 10'h003;
  localparam logic [9:0]  IDX_LDR     = 10'h005;
  localparam logic [9:0]  IDX_FLAGS   = 10'h006;
  localparam logic [9:0]  IDX_LAST    = 10'h1ff;
  // Software register offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_BASE    = 8'h04;
  localparam logic [7:0]  OFS_CPU     = 8'h08;
  localparam logic [7:0]  OFS_PLAT    = 8'h0c;
  localparam logic [7:0]  OFS_STAT    = 8'h10;
  localparam logic [7:0]  OFS_OLD     = 8'h14;
  localparam logic [7:0]  OFS_NEW     = 8'h18;
  localparam logic [7:0]  OFS_HDR     = 8'h1c;
  // Control and status bit positions
  localparam int CB_START  = 0;
  localparam int CB_SUM    = 1;
  localparam int CB_REAL   = 2;
  localparam int CB_PAGING = 3;
  localparam int CB_MAPPED = 4;
  localparam int SB_BUSY   = 0;
  localparam int SB_DONE   = 1;
  localparam int SB_OK     = 2;
  localparam int SB_RELOAD = 3;
  localparam int SB_CODE   = 8;
  typedef enum logic [1:0] {OP_WR = 2'h0, OP_RD = 2'h1, OP_ID = 2'h2} dev_op_t;
  typedef struct packed {
    dev_op_t     op;
    logic [31:0] ecx;
    logic [31:0] eax;
    logic [31:0] edx;
  } dev_req_t;
  typedef enum logic [3:0] {
    FAIL_NONE = 4'h0, FAIL_SUM = 4'h1, FAIL_LDR = 4'h2, FAIL_CPU = 4'h3,
    FAIL_OLD = 4'h4, FAIL_VERIFY = 4'h5, FAIL_SEG = 4'h6, FAIL_PAGE = 4'h7
  } fail_t;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_SCAN = 8'h02, ST_CHECK = 8'h04, ST_CLR = 8'h08,
    ST_IDN = 8'h10, ST_RDS = 8'h20, ST_TRIG = 8'h40, ST_END = 8'h80
  } state_t;
endpackage : patch_pkg
`default_nettype wire
